// ---- rtl/timer16_capture_compare_unit.sv ----
`timescale 1ns/1ps
`include "tcc_defines.svh"
module timer16_capture_compare_unit
  import tcc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic TICK_I,
  input wire logic CAP_PIN_I,
  input wire logic [2:0] IRQ_ACK_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic CAP_PIN_O,
  output logic CAP_PIN_OE_O,
  output logic WAVE_A_O,
  output logic WAVE_A_OE_O,
  output logic WAVE_B_O,
  output logic WAVE_B_OE_O,
  output logic CAP_IRQ_O,
  output logic CMPA_IRQ_O,
  output logic CMPB_IRQ_O
);
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic aw_hs, w_hs, ar_hs, wr_do, we;
  ctrl_a_t ctrl_a_reg;
  ctrl_b_t ctrl_b_reg;
  port_t port_reg;
  flags_t irq_en_reg;
  flags_t flags_reg;
  logic [7:0] temp_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cap_reg;
  logic block_reg;
  logic wave_a_reg, wave_b_reg;
  logic [7:0] rd_byte;
  logic rd_ok;
  wgm_t wgm;
  logic pwm, at_top, at_zero, load_buf;
  logic [15:0] top, cmpa_act, cmpa_cpu, cmpb_cpu;
  logic eq_a, eq_b, match_a, match_b, force_a, force_b;
  logic cap_edge, cap_src;
  logic [15:0] wr_word;

  function automatic logic addr_ok(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `TCC_PORT;
  endfunction
  function automatic logic wsel(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && a == off;
  endfunction
  function automatic logic wave_next(input logic cur, input logic [1:0] mode,
                                     input logic pwm_m, input logic match,
                                     input logic frc, input logic top_hit);
    if (mode == `TCC_OM_OFF) return cur;
    if (!pwm_m) begin
      if (match || frc) begin
        case (mode)
          `TCC_OM_TOGGLE: return ~cur;
          `TCC_OM_CLEAR: return 1'b0;
          default: return 1'b1;
        endcase
      end
      return cur;
    end
    if (mode == `TCC_OM_TOGGLE) return cur;
    if (match) return mode == `TCC_OM_CLEAR;
    if (top_hit) return mode != `TCC_OM_CLEAR;
    return cur;
  endfunction

  // ==========================================
  // AXI4-Lite write channels
  assign aw_hs = AWVALID_I & AWREADY_O;
  assign w_hs = WVALID_I & WREADY_O;
  assign wr_do = aw_full_reg & w_full_reg & ~BVALID_O;
  assign we = wr_do & wlane_reg & addr_ok(awaddr_reg);
  assign wr_word = {temp_reg, wdata_reg};

  always_ff @(posedge CLK_I) begin
    if (RST_I) aw_full_reg <= 1'b0;
    else if (aw_hs) aw_full_reg <= 1'b1;
    else if (wr_do) aw_full_reg <= 1'b0;
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) w_full_reg <= 1'b0;
    else if (w_hs) w_full_reg <= 1'b1;
    else if (wr_do) w_full_reg <= 1'b0;
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
    end else begin
      AWREADY_O <= ~aw_hs & (~aw_full_reg | wr_do);
      WREADY_O <= ~w_hs & (~w_full_reg | wr_do);
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else begin
      if (aw_hs) awaddr_reg <= AWADDR_I;
      if (w_hs) begin
        wdata_reg <= WDATA_I[7:0];
        wlane_reg <= WSTRB_I[0];
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= `TCC_RESP_OKAY;
    end else if (wr_do) begin
      BVALID_O <= 1'b1;
      BRESP_O <= addr_ok(awaddr_reg) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // ==========================================
  // AXI4-Lite read channels
  assign ar_hs = ARVALID_I & ARREADY_O;
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = addr_ok(ARADDR_I);
    case (ARADDR_I)
      `TCC_CTRL_A: rd_byte = ctrl_a_reg;
      `TCC_CTRL_B: rd_byte = ctrl_b_reg;
      `TCC_CNT_L: rd_byte = cnt_reg[7:0];
      `TCC_CNT_H, `TCC_CAP_H: rd_byte = temp_reg;
      `TCC_CAP_L: rd_byte = cap_reg[7:0];
      `TCC_CMPA_L: rd_byte = cmpa_cpu[7:0];
      `TCC_CMPA_H: rd_byte = cmpa_cpu[15:8];
      `TCC_CMPB_L: rd_byte = cmpb_cpu[7:0];
      `TCC_CMPB_H: rd_byte = cmpb_cpu[15:8];
      `TCC_IRQ_EN: rd_byte = irq_en_reg;
      `TCC_FLAGS: rd_byte = flags_reg;
      `TCC_PORT: rd_byte = port_reg;
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) ARREADY_O <= 1'b0;
    else ARREADY_O <= ~ar_hs & (~RVALID_O | RREADY_I);
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `TCC_RESP_OKAY;
    end else if (ar_hs) begin
      RVALID_O <= 1'b1;
      RDATA_O <= {24'h000000, rd_byte};
      RRESP_O <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_a_reg <= `TCC_RST_BYTE;
      ctrl_b_reg <= `TCC_RST_BYTE;
      port_reg <= `TCC_RST_BYTE;
      irq_en_reg <= `TCC_RST_BYTE;
    end else begin
      if (wsel(we, awaddr_reg, `TCC_CTRL_A)) ctrl_a_reg <= wdata_reg & `TCC_CTRL_A_MASK;
      if (wsel(we, awaddr_reg, `TCC_CTRL_B)) ctrl_b_reg <= wdata_reg & `TCC_CTRL_B_MASK;
      if (wsel(we, awaddr_reg, `TCC_PORT)) port_reg <= wdata_reg & `TCC_PORT_MASK;
      if (wsel(we, awaddr_reg, `TCC_IRQ_EN)) irq_en_reg <= wdata_reg & `TCC_FLAG_MASK;
    end
  end
  assign wgm = {ctrl_b_reg.wgm_hi, ctrl_a_reg.wgm_lo};
  assign pwm = is_pwm(wgm);
  assign force_a = wsel(we, awaddr_reg, `TCC_FORCE) & wdata_reg[`TCC_FRC_A_BIT];
  assign force_b = wsel(we, awaddr_reg, `TCC_FORCE) & wdata_reg[`TCC_FRC_B_BIT];

  // ==========================================
  // Shared high-byte latch; write beats a same-cycle read
  always_ff @(posedge CLK_I) begin
    if (RST_I) temp_reg <= 8'h00;
    else if (we && (awaddr_reg == `TCC_CNT_H || awaddr_reg == `TCC_CAP_H ||
                    awaddr_reg == `TCC_CMPA_H || awaddr_reg == `TCC_CMPB_H))
      temp_reg <= wdata_reg;
    else if (ar_hs && ARADDR_I == `TCC_CNT_L) temp_reg <= cnt_reg[15:8];
    else if (ar_hs && ARADDR_I == `TCC_CAP_L) temp_reg <= cap_reg[15:8];
  end

  // ==========================================
  // Counter, simple up count to top
  assign top = top_value(wgm, cmpa_act, cap_reg);
  assign at_top = TICK_I & (cnt_reg == top);
  assign at_zero = TICK_I & (cnt_reg == 16'h0000);
  assign load_buf = pwm & (load_at_zero(wgm) ? at_zero : at_top);
  always_ff @(posedge CLK_I) begin
    if (RST_I) cnt_reg <= 16'h0000;
    else if (wsel(we, awaddr_reg, `TCC_CNT_L)) cnt_reg <= wr_word;
    else if (at_top) cnt_reg <= 16'h0000;
    else if (TICK_I) cnt_reg <= cnt_reg + 16'h0001;
  end
  // Holds until the next tick, so a stopped timer still blocks
  always_ff @(posedge CLK_I) begin
    if (RST_I) block_reg <= 1'b0;
    else if (wsel(we, awaddr_reg, `TCC_CNT_L)) block_reg <= 1'b1;
    else if (TICK_I) block_reg <= 1'b0;
  end

  // ==========================================
  // Compare channels
  compare_channel u_cmp_a (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wr_i(wsel(we, awaddr_reg, `TCC_CMPA_L)),
    .wr_data_i(wr_word),
    .buffered_i(pwm),
    .load_i(load_buf),
    .count_i(cnt_reg),
    .active_o(cmpa_act),
    .cpu_o(cmpa_cpu),
    .equal_o(eq_a)
  );
  compare_channel u_cmp_b (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wr_i(wsel(we, awaddr_reg, `TCC_CMPB_L)),
    .wr_data_i(wr_word),
    .buffered_i(pwm),
    .load_i(load_buf),
    .count_i(cnt_reg),
    .active_o(),
    .cpu_o(cmpb_cpu),
    .equal_o(eq_b)
  );
  assign match_a = TICK_I & eq_a & ~block_reg;
  assign match_b = TICK_I & eq_b & ~block_reg;

  // ==========================================
  // Capture path; output modes stay out of it
  assign cap_src = port_reg.dir_cap ? port_reg.val_cap : CAP_PIN_I;
  capture_filter u_filter (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(cap_src),
    .filt_en_i(ctrl_b_reg.filt_en),
    .edge_rise_i(ctrl_b_reg.edge_rise),
    .enable_i(~icr_top(wgm)),
    .edge_o(cap_edge)
  );
  always_ff @(posedge CLK_I) begin
    if (RST_I) cap_reg <= 16'h0000;
    else if (cap_edge) cap_reg <= cnt_reg;
    else if (icr_top(wgm) && wsel(we, awaddr_reg, `TCC_CAP_L)) cap_reg <= wr_word;
  end

  // ==========================================
  // Flags: hardware set wins over a same-cycle clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) flags_reg <= `TCC_RST_BYTE;
    else begin
      flags_reg.cap <= cap_edge | (flags_reg.cap & ~IRQ_ACK_I[0] &
        ~(wsel(we, awaddr_reg, `TCC_FLAGS) & wdata_reg[0]));
      flags_reg.cmp_a <= match_a | (flags_reg.cmp_a & ~IRQ_ACK_I[1] &
        ~(wsel(we, awaddr_reg, `TCC_FLAGS) & wdata_reg[1]));
      flags_reg.cmp_b <= match_b | (flags_reg.cmp_b & ~IRQ_ACK_I[2] &
        ~(wsel(we, awaddr_reg, `TCC_FLAGS) & wdata_reg[2]));
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CAP_IRQ_O <= 1'b0;
      CMPA_IRQ_O <= 1'b0;
      CMPB_IRQ_O <= 1'b0;
    end else begin
      CAP_IRQ_O <= flags_reg.cap & irq_en_reg.cap;
      CMPA_IRQ_O <= flags_reg.cmp_a & irq_en_reg.cmp_a;
      CMPB_IRQ_O <= flags_reg.cmp_b & irq_en_reg.cmp_b;
    end
  end

  // ==========================================
  // Waveform state, untouched by mode changes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else begin
      wave_a_reg <= wave_next(wave_a_reg, ctrl_a_reg.mode_a, pwm, match_a, force_a, at_top);
      wave_b_reg <= wave_next(wave_b_reg, ctrl_a_reg.mode_b, pwm, match_b, force_b, at_top);
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      WAVE_A_O <= 1'b0;
      WAVE_A_OE_O <= 1'b0;
      WAVE_B_O <= 1'b0;
      WAVE_B_OE_O <= 1'b0;
      CAP_PIN_O <= 1'b0;
      CAP_PIN_OE_O <= 1'b0;
    end else begin
      WAVE_A_O <= (ctrl_a_reg.mode_a != `TCC_OM_OFF) ? wave_a_reg : port_reg.val_a;
      WAVE_A_OE_O <= port_reg.dir_a;
      WAVE_B_O <= (ctrl_a_reg.mode_b != `TCC_OM_OFF) ? wave_b_reg : port_reg.val_b;
      WAVE_B_OE_O <= port_reg.dir_b;
      CAP_PIN_O <= port_reg.val_cap;
      CAP_PIN_OE_O <= port_reg.dir_cap;
    end
  end

  // ==========================================
  // Checks
  a_capture_copy: assert property (@(posedge CLK_I) disable iff (RST_I)
    cap_edge |=> cap_reg == $past(cnt_reg) && flags_reg.cap)
    else $error("capture did not copy counter and set flag");
  a_capture_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    icr_top(wgm) && $past(icr_top(wgm)) |-> !cap_edge)
    else $error("capture fired while capture register defines top");
  a_match_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    match_a |=> flags_reg.cmp_a)
    else $error("compare match did not set flag");
  a_match_block: assert property (@(posedge CLK_I) disable iff (RST_I)
    TICK_I && block_reg |=> !$rose(flags_reg.cmp_a) && !$rose(flags_reg.cmp_b))
    else $error("match not blocked after counter write");
  a_force_noflag: assert property (@(posedge CLK_I) disable iff (RST_I)
    force_a && !match_a |=> !$rose(flags_reg.cmp_a))
    else $error("force strobe set the compare flag");
  a_force_toggle: assert property (@(posedge CLK_I) disable iff (RST_I)
    force_a && !pwm && ctrl_a_reg.mode_a == `TCC_OM_TOGGLE |=> wave_a_reg != $past(wave_a_reg))
    else $error("force strobe did not toggle output");
  a_mode_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_a_reg.mode_a == `TCC_OM_OFF |=> $stable(wave_a_reg))
    else $error("output state moved with output mode zero");
  a_pin_override: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_a_reg.mode_a != `TCC_OM_OFF |=> WAVE_A_O == $past(wave_a_reg))
    else $error("waveform did not override port value");
  a_flag_ack: assert property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_ACK_I[1] && !match_a |=> !flags_reg.cmp_a)
    else $error("service did not clear compare flag");
  a_low_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    wsel(we, awaddr_reg, `TCC_CMPA_L) && !pwm |=> cmpa_act == $past(wr_word))
    else $error("low byte write did not load all sixteen bits");
endmodule

// ---- shared/tcc_defines.svh ----
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ==========================================
// Register byte offsets
`define TCC_CTRL_A 8'h00
`define TCC_CTRL_B 8'h04
`define TCC_FORCE 8'h08
`define TCC_CNT_L 8'h0C
`define TCC_CNT_H 8'h10
`define TCC_CAP_L 8'h14
`define TCC_CAP_H 8'h18
`define TCC_CMPA_L 8'h1C
`define TCC_CMPA_H 8'h20
`define TCC_CMPB_L 8'h24
`define TCC_CMPB_H 8'h28
`define TCC_IRQ_EN 8'h2C
`define TCC_FLAGS 8'h30
`define TCC_PORT 8'h34
// ==========================================
// Write masks and reset values
`define TCC_CTRL_A_MASK 8'hF3
`define TCC_CTRL_B_MASK 8'hD8
`define TCC_PORT_MASK 8'h3F
`define TCC_FLAG_MASK 8'h07
`define TCC_RST_BYTE 8'h00
`define TCC_FRC_A_BIT 7
`define TCC_FRC_B_BIT 6
// ==========================================
// Timing, tops, codes
`define TCC_FILTER_LEN 4
`define TCC_TOP_8 16'h00FF
`define TCC_TOP_9 16'h01FF
`define TCC_TOP_10 16'h03FF
`define TCC_TOP_MAX 16'hFFFF
`define TCC_OM_OFF 2'h0
`define TCC_OM_TOGGLE 2'h1
`define TCC_OM_CLEAR 2'h2
`define TCC_OM_SET 2'h3
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`endif

// ---- shared/tcc_pkg.sv ----
`include "tcc_defines.svh"
package tcc_pkg;
  typedef logic [3:0] wgm_t;
  typedef struct packed {
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_lo;
  } ctrl_a_t;
  typedef struct packed {
    logic filt_en;
    logic edge_rise;
    logic rsvd5;
    logic [1:0] wgm_hi;
    logic [2:0] rsvd;
  } ctrl_b_t;
  typedef struct packed {
    logic [1:0] rsvd;
    logic dir_b;
    logic val_b;
    logic dir_a;
    logic val_a;
    logic dir_cap;
    logic val_cap;
  } port_t;
  typedef struct packed {
    logic [4:0] rsvd;
    logic cmp_b;
    logic cmp_a;
    logic cap;
  } flags_t;

  // Normal, CTC on A, CTC on capture, reserved: all the rest are PWM
  function automatic logic is_pwm(input wgm_t w);
    return !(w == 4'h0 || w == 4'h4 || w == 4'hC || w == 4'hD);
  endfunction
  // Modes 8, 10, 12, 14 take top from the capture register
  function automatic logic icr_top(input wgm_t w);
    return w[3] & ~w[0];
  endfunction
  // Phase and frequency correct modes reload at the zero point
  function automatic logic load_at_zero(input wgm_t w);
    return w[3:1] == 3'h4;
  endfunction
  function automatic logic [15:0] top_value(input wgm_t w, input logic [15:0] cmpa,
                                            input logic [15:0] cap);
    case (w)
      4'h1, 4'h5: return `TCC_TOP_8;
      4'h2, 4'h6: return `TCC_TOP_9;
      4'h3, 4'h7: return `TCC_TOP_10;
      4'h4, 4'h9, 4'hB, 4'hF: return cmpa;
      4'h8, 4'hA, 4'hC, 4'hE: return cap;
      default: return `TCC_TOP_MAX;
    endcase
  endfunction
endpackage

// ---- rtl/capture_filter.sv ----
`timescale 1ns/1ps
`include "tcc_defines.svh"
module capture_filter #(
  parameter int LEN = `TCC_FILTER_LEN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic filt_en_i,
  input wire logic edge_rise_i,
  input wire logic enable_i,
  output logic edge_o
);
  logic [2:0] sync_reg;
  logic level_reg;
  logic [LEN-1:0] hist_reg;
  logic filt_reg;
  logic prev_reg;
  logic det_in;

  // ==========================================
  // Synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) sync_reg <= 3'h0;
    else sync_reg <= {sync_reg[1:0], pin_i};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) level_reg <= 1'b0;
    else if (sync_reg[1] == sync_reg[2]) level_reg <= sync_reg[2];
  end
  // ==========================================
  // Four-sample filter on the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) hist_reg <= '0;
    else hist_reg <= {hist_reg[LEN-2:0], level_reg};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) filt_reg <= 1'b0;
    else if (&hist_reg || ~|hist_reg) filt_reg <= hist_reg[0];
  end
  assign det_in = filt_en_i ? filt_reg : level_reg;
  // ==========================================
  // Edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) prev_reg <= 1'b0;
    else prev_reg <= det_in;
  end
  // Switching the filter can fake an edge; software clears the flag after
  always_ff @(posedge clk_i) begin
    if (rst_i) edge_o <= 1'b0;
    else edge_o <= enable_i & (edge_rise_i ? det_in & ~prev_reg : ~det_in & prev_reg);
  end

  a_filter_settle: assert property (@(posedge clk_i) disable iff (rst_i)
    level_reg [*5] |=> filt_reg)
    else $error("filter did not follow a steady high input");
endmodule

// ---- rtl/compare_channel.sv ----
`timescale 1ns/1ps
module compare_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic buffered_i,
  input wire logic load_i,
  input wire logic [15:0] count_i,
  output logic [15:0] active_o,
  output logic [15:0] cpu_o,
  output logic equal_o
);
  logic [15:0] buf_reg;
  logic [15:0] act_reg;

  // Buffer tracks unbuffered writes too, so a mode switch starts sane
  always_ff @(posedge clk_i) begin
    if (rst_i) buf_reg <= 16'h0000;
    else if (wr_i) buf_reg <= wr_data_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) act_reg <= 16'h0000;
    else if (wr_i && !buffered_i) act_reg <= wr_data_i;
    else if (buffered_i && load_i) act_reg <= buf_reg;
  end
  assign active_o = act_reg;
  assign cpu_o = buffered_i ? buf_reg : act_reg;
  assign equal_o = count_i == act_reg;

  a_buffer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    buffered_i && !load_i |=> $stable(act_reg))
    else $error("active compare value moved outside a reload");
endmodule

// ---- verif/cap_pin_driver.sv ----
`timescale 1ns/1ps
// ==========================================
// Capture pin wire
module cap_pin_driver (
  input wire logic ext_i,
  input wire logic port_i,
  input wire logic oe_i,
  output logic pin_o
);
  // The port wins while it drives the pin, otherwise the outside source
  assign pin_o = oe_i ? port_i : ext_i;
endmodule

// ---- verif/timer16_capture_compare_unit_test.sv ----
`timescale 1ns/1ps
`include "tcc_defines.svh"
module timer16_capture_compare_unit_test;
  import tcc_pkg::*;
  logic clk = 0, rst = 1, tick = 0, ext = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [2:0] ack = 3'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr_o, bv, arr, rv, pin, cpo, cpoe, wa, waoe, wb, wboe, cirq, airq, birq;
  int mismatches = 0, n_checks = 0, cyc = 0, seed = 45237;
  logic [15:0] c, c2;
  logic [31:0] d;
  logic [1:0] br, rr;
  logic [3:0] ws = 4'hF;
  logic [15:0] exp_q[$];
  always #5 clk = ~clk;
  cap_pin_driver u_pin (.ext_i(ext), .port_i(cpo), .oe_i(cpoe), .pin_o(pin));
  timer16_capture_compare_unit DUT (.CLK_I(clk), .RST_I(rst), .TICK_I(tick), .CAP_PIN_I(pin),
    .IRQ_ACK_I(ack), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wr_o), .BRESP_O(br), .BVALID_O(bv),
    .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rd),
    .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry), .CAP_PIN_O(cpo), .CAP_PIN_OE_O(cpoe),
    .WAVE_A_O(wa), .WAVE_A_OE_O(waoe), .WAVE_B_O(wb), .WAVE_B_OE_O(wboe),
    .CAP_IRQ_O(cirq), .CMPA_IRQ_O(airq), .CMPB_IRQ_O(birq));
  task wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Aligned words up to the port register answer OKAY, all else SLVERR
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a[1:0] == 2'h0 && a <= `TCC_PORT) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; bry <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
      if (!dd && wr_o === 1'b1) begin dd = 1; wv <= 0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    chk("bresp", exp_resp(a), br);
    bry <= 0;
    // One idle edge so a following call never re-raises bready in this step
    @(posedge clk);
  endtask
  task rdr(input logic [7:0] a, output logic [31:0] v);
    ara <= a; arv <= 1; rry <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    while (rv !== 1'b1) @(posedge clk);
    v = rd;
    chk("rresp", exp_resp(a), rr);
    rry <= 0;
    @(posedge clk);
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    rdr(a, d);
    chk(n, {24'h0, e}, d);
  endtask
  task w16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task tk;
    tick <= 1;
    @(posedge clk);
    tick <= 0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    chk("wave_a", 0, wa);
    rchk("flags", `TCC_FLAGS, 8'h00);
    c = 16'($random(seed));
    w16(`TCC_CNT_L, c);
    wr(`TCC_CTRL_B, 8'h40);
    wr(`TCC_FLAGS, 8'h07);
    ext <= 1;
    exp_q.push_back(c);
    repeat (20) @(posedge clk);
    rchk("cap_flag", `TCC_FLAGS, 8'h01);
    rchk("cap_lo", `TCC_CAP_L, exp_q[0][7:0]);
    rchk("cap_hi", `TCC_CAP_H, exp_q[0][15:8]);
    exp_q.delete(0);
    // Second capture from the port, filtered, flag still standing
    ext <= 0;
    wr(`TCC_CTRL_B, 8'hC0);
    c2 = 16'($random(seed));
    w16(`TCC_CNT_L, c2);
    wr(`TCC_PORT, 8'h03);
    exp_q.push_back(c2);
    repeat (24) @(posedge clk);
    chk("cap_pin", 1, cpo);
    chk("cap_pin_oe", 1, cpoe);
    rchk("cap_lo2", `TCC_CAP_L, exp_q[0][7:0]);
    rchk("cap_hi2", `TCC_CAP_H, exp_q[0][15:8]);
    exp_q.delete(0);
    wr(`TCC_CTRL_B, 8'h80);
    wr(`TCC_FLAGS, 8'h01);
    rchk("flag_w1c", `TCC_FLAGS, 8'h00);
    wr(`TCC_PORT, 8'h02);
    exp_q.push_back(c2);
    repeat (24) @(posedge clk);
    rchk("cap_lo3", `TCC_CAP_L, exp_q[0][7:0]);
    exp_q.delete(0);
    wr(`TCC_IRQ_EN, 8'h01);
    chk("cap_irq", 1, cirq);
    ack <= 3'h1;
    @(posedge clk);
    ack <= 3'h0;
    repeat (2) @(posedge clk);
    rchk("flag_ack", `TCC_FLAGS, 8'h00);
    // Write with the low byte lane off must leave the register alone
    ws <= 4'hE;
    wr(`TCC_IRQ_EN, 8'h00);
    ws <= 4'hF;
    rchk("irq_en_kept", `TCC_IRQ_EN, 8'h01);
    wr(8'h38, 8'hFF);
    rchk("bad_addr", 8'h38, 8'h00);
    // Compare: counter write equal to compare value must not match
    wr(`TCC_CTRL_A, 8'hC0);
    wr(`TCC_PORT, 8'h08);
    c = {c[15:8], 8'h10};
    w16(`TCC_CMPA_L, c);
    w16(`TCC_CNT_L, c);
    tk;
    rchk("blocked", `TCC_FLAGS, 8'h00);
    w16(`TCC_CMPA_L, c + 16'h0002);
    tk;
    tk;
    rchk("cmp_flag", `TCC_FLAGS, 8'h02);
    chk("wave_set", 1, wa);
    chk("wave_a_oe", 1, waoe);
    chk("wave_b", 0, wb);
    chk("wave_b_oe", 0, wboe);
    chk("cap_pin_rel", 0, cpoe);
    wr(`TCC_IRQ_EN, 8'h06);
    chk("cmpa_irq", 1, airq);
    chk("cmpb_irq", 0, birq);
    wr(`TCC_CTRL_A, 8'h40);
    wr(`TCC_FORCE, 8'h80);
    @(posedge clk);
    chk("wave_frc", 0, wa);
    rchk("frc_flag", `TCC_FLAGS, 8'h02);
    wrap_up;
  end
endmodule
